/* lcdst_pkg.sv */
package lcdst_pkg;
  // ==========================================================
  // Clock and oscillator rates
  // ==========================================================
  localparam int CLK_HZ = 125_000_000;
  localparam int OSC_FAST_HZ = 31_400;
  localparam int OSC_SLOW_HZ = 26_300;
  localparam int OSC_FAST_CYC = CLK_HZ / OSC_FAST_HZ;
  localparam int OSC_SLOW_CYC = CLK_HZ / OSC_SLOW_HZ;
  localparam int OSC_CNT_W = 13;

  // ==========================================================
  // Memory geometry
  // ==========================================================
  localparam int NUM_LINES = 65;
  localparam int NUM_COLS = 132;
  localparam int PAGE_BITS = 8;
  localparam int COM_PADS = 64;
  localparam logic [7:0] COL_LAST = 8'h83;
  localparam logic [3:0] PAGE_EXTRA = 4'h8;
  localparam logic [6:0] LINES_TOTAL = 7'h41;

  // ==========================================================
  // Register port
  // ==========================================================
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PAGE = 4'h1;
  localparam logic [3:0] REG_COLUMN = 4'h2;
  localparam logic [3:0] REG_START = 4'h3;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;

  localparam int CTRL_ADC = 0;
  localparam int CTRL_COM_REV = 1;
  localparam int CTRL_DISP_ON = 2;
  localparam int CTRL_REV_VIDEO = 3;
  localparam int CTRL_ALL_ON = 4;
  localparam int CTRL_OSC_SLOW = 5;
  localparam int CTRL_PART_LO = 6;
  localparam int CTRL_PART_HI = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] PART_NONE = 2'h0;
  localparam logic [1:0] PART_17 = 2'h1;

  localparam int STAT_FR = 7;

  // ==========================================================
  // Duty ratios
  // ==========================================================
  typedef enum {DUTY_65, DUTY_49, DUTY_33, DUTY_17, DUTY_9} lcdst_duty_type;

  localparam logic [5:0] DIV_65 = 6'h06;
  localparam logic [5:0] DIV_49 = 6'h08;
  localparam logic [5:0] DIV_33 = 6'h0c;
  localparam logic [5:0] DIV_17 = 6'h16;
  localparam logic [5:0] DIV_9 = 6'h2c;

  localparam logic [6:0] ROWS_65 = 7'h41;
  localparam logic [6:0] ROWS_49 = 7'h31;
  localparam logic [6:0] ROWS_33 = 7'h21;
  localparam logic [6:0] ROWS_17 = 7'h11;
  localparam logic [6:0] ROWS_9 = 7'h09;
endpackage

/* lcdst_line_clock.sv */
`timescale 1ns/1ps
module lcdst_line_clock #(
  parameter int P_OSC_FAST_CYC = lcdst_pkg::OSC_FAST_CYC,
  parameter int P_OSC_SLOW_CYC = lcdst_pkg::OSC_SLOW_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_osc_run,
  input wire logic i_osc_slow,
  input wire logic [5:0] i_divisor,
  input wire logic i_ext_line,
  output logic o_line_tick,
  output logic o_line_level
);
  import lcdst_pkg::*;

  localparam logic [OSC_CNT_W-1:0] FAST_LAST = OSC_CNT_W'(P_OSC_FAST_CYC - 1);
  localparam logic [OSC_CNT_W-1:0] SLOW_LAST = OSC_CNT_W'(P_OSC_SLOW_CYC - 1);

  logic [OSC_CNT_W-1:0] osc_cnt_r;
  logic osc_pulse_r;
  logic [5:0] div_cnt_r;
  logic ext_prev_r;
  logic level_r;

  // ==========================================================
  // Oscillator model: one enable pulse per oscillator period
  // ==========================================================
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !i_osc_run) begin
      osc_cnt_r <= '0;
      osc_pulse_r <= 1'b0;
    end else if (osc_cnt_r >= (i_osc_slow ? SLOW_LAST : FAST_LAST)) begin
      osc_cnt_r <= '0;
      osc_pulse_r <= 1'b1;
    end else begin
      osc_cnt_r <= osc_cnt_r + 1'b1;
      osc_pulse_r <= 1'b0;
    end
  end

  // ==========================================================
  // Line clock: oscillator divided by the duty divisor
  // ==========================================================
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || !i_osc_run) begin
      div_cnt_r <= '0;
      level_r <= 1'b0;
    end else if (osc_pulse_r) begin
      div_cnt_r <= (div_cnt_r >= i_divisor - 6'h01) ? 6'h00 : div_cnt_r + 6'h01;
      level_r <= (div_cnt_r >= i_divisor - 6'h01) || (div_cnt_r + 6'h01 < (i_divisor >> 1));
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= i_ext_line;
    end
  end

  // Tick on the rising edge of whichever line clock is in use
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_line_tick <= 1'b0;
      o_line_level <= 1'b0;
    end else if (i_osc_run) begin
      o_line_tick <= osc_pulse_r && (div_cnt_r >= i_divisor - 6'h01);
      o_line_level <= level_r;
    end else begin
      o_line_tick <= i_ext_line && !ext_prev_r;
      o_line_level <= i_ext_line;
    end
  end
endmodule // lcdst_line_clock

/* lcdst_scan_top.sv */
// Overview of operation
// - Memory is 65 lines by 132 columns, paged
// - Page 8 keeps only data bit 0
// - Column address increments after each data access
// - Column increment stops at 83h, page untouched
// - Segment direction select reverses column mapping
// - Start line shown on row 0 or 63
// - Display spans 65/49/33/17/9 lines from start line, per duty
// - Video modes act on latch, not memory
// - Host access never disturbs refresh fetch
// - Fetched row latched per line clock tick
// - Polarity alternates every frame, two-frame drive
// - Oscillator runs only as master with internal clock
// - Master drives polarity and off sync, line clock only with internal clock; slave uses them
// - Oscillator selectable at 31.4 or 26.3 kHz
// - Line clock divides oscillator by 6/8/12/22/44
// - Polarity rate is line clock over 2N
// - Row order selectable, unused middle pads idle
// - Duty pins select 65, 49 or 33 rows
`timescale 1ns/1ps
module lcdst_scan_top #(
  parameter int P_OSC_FAST_CYC = lcdst_pkg::OSC_FAST_CYC,
  parameter int P_OSC_SLOW_CYC = lcdst_pkg::OSC_SLOW_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [lcdst_pkg::ADDR_W-1:0] i_addr,
  input wire logic [lcdst_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [lcdst_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_master_slave_select,
  input wire logic i_clock_source_select,
  input wire logic i_duty_cfg_bit0,
  input wire logic i_duty_cfg_bit1,
  input wire logic i_display_line_tick,
  output logic o_display_line_tick,
  output logic o_display_line_tick_oe,
  input wire logic i_lcd_ac_polarity,
  output logic o_lcd_ac_polarity,
  output logic o_lcd_ac_polarity_oe,
  input wire logic i_display_off_sync_b,
  output logic o_display_off_sync_b,
  output logic o_display_off_sync_oe,
  output logic [lcdst_pkg::NUM_COLS-1:0] o_column_driver_output,
  output logic [lcdst_pkg::COM_PADS-1:0] o_row_output,
  output logic o_indicator_row_output
);
  import lcdst_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic lcdst_duty_type duty_of(input logic b1, input logic b0, input logic [1:0] part);
    if (part == PART_17) begin
      return DUTY_17;
    end else if (part != PART_NONE) begin
      return DUTY_9;
    end else if (b1) begin
      return DUTY_65;
    end else if (b0) begin
      return DUTY_49;
    end
    return DUTY_33;
  endfunction

  function automatic logic [6:0] rows_of(input lcdst_duty_type d);
    unique case (d)
      DUTY_65: return ROWS_65;
      DUTY_49: return ROWS_49;
      DUTY_33: return ROWS_33;
      DUTY_17: return ROWS_17;
      DUTY_9: return ROWS_9;
    endcase
  endfunction

  function automatic logic [5:0] div_of(input lcdst_duty_type d);
    unique case (d)
      DUTY_65: return DIV_65;
      DUTY_49: return DIV_49;
      DUTY_33: return DIV_33;
      DUTY_17: return DIV_17;
      DUTY_9: return DIV_9;
    endcase
  endfunction

  // Start line plus offset, wrapped into the 65-line memory
  function automatic logic [6:0] wrap_line(input logic [6:0] a, input logic [6:0] b);
    logic [7:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, LINES_TOTAL}) begin
      s = s - {1'b0, LINES_TOTAL};
    end
    return s[6:0];
  endfunction

  // Memory line that bit k of a page byte maps to
  function automatic int line_of(input logic [3:0] page, input int k);
    return int'(page) * PAGE_BITS + k;
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  logic [NUM_COLS-1:0] ram_r [NUM_LINES];
  logic [7:0] ctrl_r;
  logic [3:0] page_r;
  logic [7:0] col_r;
  logic [5:0] start_r;
  logic [7:0] holder_r;
  logic [6:0] row_cnt_r;
  logic fr_r;
  logic fr_in_prev_r;

  lcdst_duty_type duty;
  logic [6:0] rows;
  logic [6:0] half;
  logic is_master;
  logic osc_run;
  logic line_tick;
  logic line_level;
  logic disp_on;
  logic frame_restart;
  logic [6:0] fetch_line;
  logic [NUM_COLS-1:0] fetch_row;
  logic [NUM_COLS-1:0] seg_nxt;
  logic [COM_PADS-1:0] com_nxt;
  logic [6:0] pad_idx;
  logic [7:0] rd_byte;
  logic data_acc;
  logic data_wr;
  logic data_rd;
  logic frame_end;
  logic [6:0] span;

  assign duty = duty_of(i_duty_cfg_bit1, i_duty_cfg_bit0, ctrl_r[CTRL_PART_HI:CTRL_PART_LO]);
  assign rows = rows_of(duty);
  assign half = rows >> 1;
  assign span = half << 1;
  assign is_master = i_master_slave_select;
  assign osc_run = is_master && i_clock_source_select;
  assign data_wr = i_wr && (i_addr == REG_DATA);
  assign data_rd = i_rd && (i_addr == REG_DATA);
  assign data_acc = data_wr || data_rd;

  // ==========================================================
  // Line clock source
  // ==========================================================
  lcdst_line_clock #(
    .P_OSC_FAST_CYC(P_OSC_FAST_CYC),
    .P_OSC_SLOW_CYC(P_OSC_SLOW_CYC)
  ) u_line_clock (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_osc_run(osc_run),
    .i_osc_slow(ctrl_r[CTRL_OSC_SLOW]),
    .i_divisor(div_of(duty)),
    .i_ext_line(i_display_line_tick),
    .o_line_tick(line_tick),
    .o_line_level(line_level)
  );

  // ==========================================================
  // Control registers
  // ==========================================================
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ctrl_r <= CTRL_RST;
      start_r <= '0;
      page_r <= '0;
    end else if (i_wr) begin
      if (i_addr == REG_CTRL) begin
        ctrl_r <= i_wdata;
      end
      if (i_addr == REG_START) begin
        start_r <= i_wdata[5:0];
      end
      if (i_addr == REG_PAGE) begin
        page_r <= i_wdata[3:0];
      end
    end
  end

  // Column address: set by host, bumped by each data access below 83h
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      col_r <= '0;
    end else if (i_wr && i_addr == REG_COLUMN) begin
      col_r <= i_wdata;
    end else if (data_acc && col_r < COL_LAST) begin
      col_r <= col_r + 8'h01;
    end
  end

  // ==========================================================
  // Display memory, host side
  // ==========================================================
  always_comb begin
    rd_byte = '0;
    for (int k = 0; k < PAGE_BITS; k++) begin
      if (line_of(page_r, k) < NUM_LINES && int'(col_r) < NUM_COLS) begin
        rd_byte[k] = ram_r[line_of(page_r, k)][col_r];
      end
    end
  end

  // Page 8 holds one line only, so only bit 0 lands
  always_ff @(posedge i_mclk) begin
    if (data_wr && int'(col_r) < NUM_COLS) begin
      for (int k = 0; k < PAGE_BITS; k++) begin
        if (line_of(page_r, k) < NUM_LINES) begin
          ram_r[line_of(page_r, k)][col_r] <= i_wdata[k];
        end
      end
    end
  end

  // Bus holder: a data read returns the byte fetched by the previous read
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      holder_r <= '0;
    end else if (data_rd) begin
      holder_r <= rd_byte;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      unique case (i_addr)
        REG_CTRL: o_rdata <= ctrl_r;
        REG_PAGE: o_rdata <= {4'h0, page_r};
        REG_COLUMN: o_rdata <= col_r;
        REG_START: o_rdata <= {2'h0, start_r};
        REG_DATA: o_rdata <= holder_r;
        REG_STATUS: o_rdata <= {fr_r, row_cnt_r};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // ==========================================================
  // Scan counters and polarity
  // ==========================================================
  // A slave restarts its row count on every polarity edge from the master
  assign frame_restart = !is_master && (i_lcd_ac_polarity != fr_in_prev_r);
  assign frame_end = row_cnt_r >= rows - 7'h01;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      fr_in_prev_r <= 1'b0;
    end else begin
      fr_in_prev_r <= i_lcd_ac_polarity;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b || frame_restart) begin
      row_cnt_r <= '0;
    end else if (line_tick) begin
      row_cnt_r <= frame_end ? 7'h00 : row_cnt_r + 7'h01;
    end
  end

  // Toggle once per frame: one full cycle spans two frames
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      fr_r <= 1'b0;
    end else if (!is_master) begin
      fr_r <= i_lcd_ac_polarity;
    end else if (line_tick && frame_end) begin
      fr_r <= !fr_r;
    end
  end

  // ==========================================================
  // Row fetch and output latch
  // ==========================================================
  assign fetch_line = wrap_line({1'b0, start_r}, row_cnt_r);
  assign fetch_row = ram_r[fetch_line];
  assign disp_on = is_master ? ctrl_r[CTRL_DISP_ON] : i_display_off_sync_b;

  generate
    for (genvar i = 0; i < NUM_COLS; i++) begin : g_seg
      logic bit_sel;
      assign bit_sel = ctrl_r[CTRL_ADC] ? fetch_row[NUM_COLS-1-i] : fetch_row[i];
      assign seg_nxt[i] = ctrl_r[CTRL_ALL_ON] || (disp_on && (bit_sel ^ ctrl_r[CTRL_REV_VIDEO]));
    end
  endgenerate

  // Rows split into two halves; middle pads idle at reduced duty
  always_comb begin
    com_nxt = '0;
    pad_idx = '0;
    if (row_cnt_r < span) begin
      if (ctrl_r[CTRL_COM_REV]) begin
        pad_idx = (row_cnt_r < half) ? 7'(COM_PADS - 1) - row_cnt_r : span - 7'h01 - row_cnt_r;
      end else begin
        pad_idx = (row_cnt_r < half) ? row_cnt_r : row_cnt_r + 7'(COM_PADS) - span;
      end
      com_nxt[pad_idx[5:0]] = disp_on;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_column_driver_output <= '0;
      o_row_output <= '0;
      o_indicator_row_output <= 1'b0;
    end else if (line_tick) begin
      o_column_driver_output <= seg_nxt;
      o_row_output <= com_nxt;
      o_indicator_row_output <= disp_on && (row_cnt_r == span);
    end
  end

  // ==========================================================
  // Sync pins
  // ==========================================================
  // Enables follow the mode so a slave leaves these pins to the master
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_lcd_ac_polarity <= 1'b0;
      o_lcd_ac_polarity_oe <= 1'b0;
      o_display_line_tick <= 1'b0;
      o_display_line_tick_oe <= 1'b0;
      o_display_off_sync_b <= 1'b0;
      o_display_off_sync_oe <= 1'b0;
    end else begin
      o_lcd_ac_polarity <= fr_r;
      o_lcd_ac_polarity_oe <= is_master;
      o_display_line_tick <= line_level;
      o_display_line_tick_oe <= osc_run;
      o_display_off_sync_b <= ctrl_r[CTRL_DISP_ON];
      o_display_off_sync_oe <= is_master;
    end
  end
endmodule // lcdst_scan_top

/* lcdst_scan_top_assertions.sv */
`timescale 1ns/1ps
// ========================================
// Port checker
// ========================================
module lcdst_scan_chk (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [lcdst_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_rd,
  input wire logic [lcdst_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_master_slave_select,
  input wire logic i_clock_source_select,
  input wire logic i_display_line_tick,
  input wire logic o_display_line_tick_oe,
  input wire logic o_lcd_ac_polarity_oe,
  input wire logic o_display_off_sync_b,
  input wire logic o_display_off_sync_oe,
  input wire logic [lcdst_pkg::COM_PADS-1:0] o_row_output,
  input wire logic o_indicator_row_output
);
  import lcdst_pkg::*;
  logic tick_q_r;
  logic [3:0] gap_r;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // Cycles since the last rising edge of the external line clock
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      tick_q_r <= 1'b0;
      gap_r <= 4'hf;
    end else begin
      tick_q_r <= i_display_line_tick;
      if (i_display_line_tick && !tick_q_r) begin
        gap_r <= 4'h0;
      end else if (gap_r != 4'hf) begin
        gap_r <= gap_r + 4'h1;
      end
    end
  end
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_rd_unmap;
    $past(i_rd) && ($past(i_addr) > REG_STATUS) |-> o_rdata == '0;
  endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
  property p_oe_line;
    $past(i_rst_b) && $stable(i_master_slave_select) && $stable(i_clock_source_select)
      |-> o_display_line_tick_oe == (i_master_slave_select && i_clock_source_select);
  endproperty
  a_oe_line: assert property (p_oe_line) else $error("line clock enable wrong");
  property p_oe_pol;
    $past(i_rst_b) && $stable(i_master_slave_select) |-> o_lcd_ac_polarity_oe == i_master_slave_select;
  endproperty
  a_oe_pol: assert property (p_oe_pol) else $error("polarity enable wrong");
  property p_oe_off;
    $past(i_rst_b) && $stable(i_master_slave_select) |-> o_display_off_sync_oe == i_master_slave_select;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("display off sync enable wrong");
  property p_onehot;
    $onehot0(o_row_output);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one row active");
  property p_ind;
    o_indicator_row_output |-> o_row_output == '0;
  endproperty
  a_ind: assert property (p_ind) else $error("indicator row with other row");
  property p_row_tick;
    !(i_master_slave_select && i_clock_source_select) && $stable(o_display_off_sync_b)
      && (i_master_slave_select == $past(i_master_slave_select, 4))
      && (i_clock_source_select == $past(i_clock_source_select, 4))
      && $changed(o_row_output) |-> gap_r <= 4'ha;
  endproperty
  a_row_tick: assert property (p_row_tick) else $error("rows moved without line clock");
endmodule // lcdst_scan_chk

bind lcdst_scan_top lcdst_scan_chk chk_u (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_master_slave_select(i_master_slave_select), .i_clock_source_select(i_clock_source_select),
  .i_display_line_tick(i_display_line_tick), .o_display_line_tick_oe(o_display_line_tick_oe),
  .o_lcd_ac_polarity_oe(o_lcd_ac_polarity_oe), .o_display_off_sync_b(o_display_off_sync_b),
  .o_display_off_sync_oe(o_display_off_sync_oe), .o_row_output(o_row_output),
  .o_indicator_row_output(o_indicator_row_output)
);

/* lcdst_sync_src.sv */
`timescale 1ns/1ps
// ========================================
// Master chip timing source
// ========================================
module lcdst_sync_src #(
  parameter int P_PER = 20,
  parameter int P_ROWS = 65
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  output logic o_line_tick,
  output logic o_pol,
  output logic o_off_b
);
  int cyc_r;
  int line_r;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      cyc_r <= 0;
      line_r <= 0;
      o_line_tick <= 1'b0;
      o_pol <= 1'b0;
    end else begin
      cyc_r <= (cyc_r == P_PER - 1) ? 0 : cyc_r + 1;
      o_line_tick <= (cyc_r < P_PER / 2);
      if (cyc_r == P_PER - 1) begin
        line_r <= (line_r == P_ROWS - 1) ? 0 : line_r + 1;
        if (line_r == P_ROWS - 1) begin
          o_pol <= ~o_pol;
        end
      end
    end
  end
  assign o_off_b = 1'b1;
endmodule // lcdst_sync_src

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import lcdst_pkg::*;
  localparam int PER = 20;
  localparam int OF = 4;
  localparam int OS = 5;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wd = '0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic ms = 1'b1;
  logic csrc = 1'b1;
  logic [1:0] dty = 2'b10;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] v;
  logic lt_o, lt_oe, pol_o, pol_oe, off_o, off_oe, ext_tick, ext_pol, ext_off_b, ind;
  logic [NUM_COLS-1:0] col_o;
  logic [COM_PADS-1:0] row;
  logic [7:0] ct [7] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h44, 8'h84, 8'h24};
  logic [1:0] dt [7] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b10, 2'b10, 2'b10};
  int ex [7] = '{65*6*OF, 65*6*OF, 49*8*OF, 33*12*OF, 17*22*OF, 9*44*OF, 65*6*OS};
  int n_mismatch = 0;
  int samples_checked = 0;
  int k;
  wire line_w = lt_oe ? lt_o : ext_tick;
  wire pol_w = pol_oe ? pol_o : ext_pol;
  wire off_w = off_oe ? off_o : ext_off_b;
  wire [COM_PADS:0] rowx = {ind, row};
  always #4 i_mclk = ~i_mclk;
  lcdst_scan_top #(.P_OSC_FAST_CYC(OF), .P_OSC_SLOW_CYC(OS)) dut_u (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(adr), .i_wdata(wd), .i_wr(wr_s), .i_rd(rd_s),
    .o_rdata(rdata), .i_master_slave_select(ms), .i_clock_source_select(csrc),
    .i_duty_cfg_bit0(dty[0]), .i_duty_cfg_bit1(dty[1]), .i_display_line_tick(line_w),
    .o_display_line_tick(lt_o), .o_display_line_tick_oe(lt_oe), .i_lcd_ac_polarity(pol_w),
    .o_lcd_ac_polarity(pol_o), .o_lcd_ac_polarity_oe(pol_oe), .i_display_off_sync_b(off_w),
    .o_display_off_sync_b(off_o), .o_display_off_sync_oe(off_oe), .o_column_driver_output(col_o),
    .o_row_output(row), .o_indicator_row_output(ind)
  );
  lcdst_sync_src #(.P_PER(PER), .P_ROWS(65)) src_u (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .o_line_tick(ext_tick), .o_pol(ext_pol), .o_off_b(ext_off_b)
  );
  // ========================================
  // Bus and check tasks
  // ========================================
  task automatic chk(input string nm, input logic [131:0] e, input logic [131:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    adr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge i_mclk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    adr <= a;
    rd_s <= 1'b1;
    @(posedge i_mclk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rdc(input logic [7:0] e);
    logic [7:0] g;
    rd(REG_DATA, g);
    chk("data", 132'(e), 132'(g));
  endtask
  task automatic sa(input logic [3:0] p, input logic [7:0] c);
    wr(REG_PAGE, {4'h0, p});
    wr(REG_COLUMN, c);
  endtask
  task automatic ra(input logic [3:0] p, input logic [7:0] c);
    sa(p, c);
    rd(REG_DATA, v);
  endtask
  task automatic wtp(output int n);
    logic p;
    p = pol_o;
    n = 0;
    while (pol_o === p && n < 7000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
  endtask
  task automatic sc(input int p, input int s, input logic e);
    int n;
    #1;
    n = 0;
    while (rowx[p] === 1'b1 && n < 9000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    while (rowx[p] !== 1'b1 && n < 9000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk("row", 132'(1), 132'(rowx[p]));
    chk("column", 132'(e), 132'(col_o[s]));
  endtask
  task automatic frm(input logic [7:0] c, input logic [1:0] d, input int e);
    wr(REG_CTRL, c);
    dty <= d;
    wtp(k);
    wtp(k);
    wtp(k);
    chk("frame", 132'(e), 132'(k));
  endtask
  task automatic lck;
    int n;
    n = 0;
    for (int j = 0; j < 4; j++) begin
      if (j == 2) begin
        n = 0;
      end
      while ((lt_o === 1'b1) == j[0] && n < 99) begin
        @(posedge i_mclk);
        #1;
        n++;
      end
    end
    chk("line clock", 132'(6 * OF), 132'(n));
  endtask
  task automatic conclude;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ========================================
  // Tests
  // ========================================
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    sa(4'h0, 8'h82);
    wr(REG_DATA, 8'h11);
    wr(REG_DATA, 8'h22);
    wr(REG_DATA, 8'h33);
    ra(4'h0, 8'h82);
    rdc(8'h11);
    rdc(8'h33);
    sa(4'h0, 8'h00);
    wr(REG_DATA, 8'h01);
    sa(4'h7, 8'h00);
    wr(REG_DATA, 8'h00);
    sa(4'h8, 8'h00);
    wr(REG_DATA, 8'hff);
    ra(4'h8, 8'h00);
    rdc(8'h01);
    ra(4'h7, 8'h00);
    rdc(8'h00);
    wr(REG_START, 8'h3f);
    rd(REG_START, v);
    chk("start", 132'(8'h3f), 132'(v));
    rd(4'h9, v);
    chk("unmapped", '0, 132'(v));
    wr(REG_CTRL, 8'h04);
    sc(0, 0, 1'b0);
    sc(1, 0, 1'b1);
    sc(2, 0, 1'b1);
    sc(3, 0, 1'b0);
    sc(64, 0, 1'b0);
    chk("off sync", 132'(1), 132'(off_o));
    wr(REG_CTRL, 8'h06);
    sc(63, 0, 1'b0);
    sc(62, 0, 1'b1);
    sc(61, 0, 1'b1);
    wr(REG_CTRL, 8'h05);
    sc(1, 131, 1'b1);
    sc(3, 131, 1'b0);
    wr(REG_CTRL, 8'h0c);
    sc(1, 0, 1'b0);
    ra(4'h8, 8'h00);
    rdc(8'h01);
    csrc <= 1'b0;
    frm(8'h04, 2'b00, 33 * PER);
    ms <= 1'b0;
    sc(2, 0, 1'b1);
    ms <= 1'b1;
    csrc <= 1'b1;
    dty <= 2'b10;
    wr(REG_CTRL, 8'h00);
    wtp(k);
    wtp(k);
    chk("rows", '0, 132'(row));
    chk("off sync", '0, 132'(off_o));
    lck();
    for (int i = 0; i < 7; i++) begin
      frm(ct[i], dt[i], ex[i]);
    end
    conclude();
  end
  initial begin
    repeat (99000) @(posedge i_mclk);
    n_mismatch++;
    conclude();
  end
endmodule // tb
